// ===== hw/scan_select_pkg.sv
/*
 Package for the scan-start and configuration-selection block: register map,
 field positions, reset values, mode enums and carrier structs.
 Assumes an APB master with 32-bit data and word-aligned registers.
*/
package scan_select_pkg;

	localparam int ADDR_W = 12;
	localparam int NCH = 16;
	localparam int CH_W = 4;
	localparam int HALF = 8;
	localparam int EVT_W = 8;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
	localparam logic [ADDR_W-1:0] CMD_ADDR = 12'h004;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h008;
	localparam logic [ADDR_W-1:0] TOGGLE_ADDR = 12'h00c;

	// Control, command and status field positions
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 1;
	localparam int SRC_LSB = 2;
	localparam int SRC_MSB = 4;
	localparam int MAP_LSB = 7;
	localparam int MAP_MSB = 8;
	localparam int START_BIT = 0;
	localparam int STOP_BIT = 1;
	localparam int BUSY_BIT = 0;
	localparam int PEND_BIT = 1;

	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_019f;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {MAP_DIRECT, MAP_SWAPPED, MAP_TOGGLE, MAP_DECODER} map_type;
	typedef enum logic [1:0] {TRIG_PERIODIC, TRIG_SINGLE, TRIG_EVENT, TRIG_UNUSED} trig_type;

	typedef struct packed {
		logic [MAP_MSB-MAP_LSB:0] mapSel;
		logic [SRC_MSB-SRC_LSB:0] srcSel;
		logic [MODE_MSB-MODE_LSB:0] trigMode;
	} ctrl_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_type;

	// Configuration index for a channel, half-swapped when asked
	function automatic logic [CH_W-1:0] cfg_index(input logic [CH_W-1:0] ch, input logic swap);
		cfg_index = swap ? (ch ^ CH_W'(HALF)) : ch;
	endfunction : cfg_index

endpackage : scan_select_pkg

// ===== hw/event_sync.sv
/*
 Two-flop synchroniser and rising-edge detector for the event-routing inputs.
 Assumes the event inputs come from outside the sys_clk domain.
*/
`timescale 1ns/1ps
module event_sync
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Events
	input wire logic [scan_select_pkg::EVT_W-1:0] eventIn,
	output logic [scan_select_pkg::EVT_W-1:0] eventPulse
);
	import scan_select_pkg::*;

	logic [EVT_W-1:0] meta_q;
	logic [EVT_W-1:0] sync_q;
	logic [EVT_W-1:0] last_q;

	// Only the second stage is looked at
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
		end
		else
		begin
			meta_q <= eventIn;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign eventPulse = sync_q & ~last_q;

endmodule : event_sync

// ===== hw/scan_config_select.sv
/*
 Scan-start and channel-configuration selection with an APB register port.
 Assumes period overflow, channel trigger and decoder inputs are on sys_clk;
 event-routing inputs are asynchronous and synchronised here.
*/
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module scan_config_select
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [scan_select_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// Sequencer side
	input wire logic periodOverflow,
	input wire logic [scan_select_pkg::EVT_W-1:0] eventIn,
	input wire logic scanDone,
	input wire logic [scan_select_pkg::NCH-1:0] chanTrigger,
	input wire logic [scan_select_pkg::NCH-1:0] decoderSwap,
	input wire logic [scan_select_pkg::CH_W-1:0] activeChan,
	// Results
	output logic scanStart,
	output logic scanBusy,
	output logic [scan_select_pkg::CH_W-1:0] configIndex
);
	import scan_select_pkg::*;

	apb_req_type req;
	apb_rsp_type rsp;
	logic [31:0] rdHold_q;
	ctrl_type ctrl_q;
	logic [NCH-1:0] toggle_q;
	logic pending_q;
	logic busy_q;
	logic start_q;
	logic [CH_W-1:0] cfg_q;
	logic [EVT_W-1:0] eventPulse;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	event_sync u_sync
	(
		.sys_clk(sys_clk),
		.resetn(resetn),
		.eventIn(eventIn),
		.eventPulse(eventPulse)
	);

	// Register decode
	wire access = req.psel && req.penable;
	wire wrEn = access && req.pwrite;
	wire hitCtrl = req.paddr == CTRL_ADDR;
	wire hitCmd = req.paddr == CMD_ADDR;
	wire hitStatus = req.paddr == STATUS_ADDR;
	wire hitToggle = req.paddr == TOGGLE_ADDR;
	wire mapped = hitCtrl || hitCmd || hitStatus || hitToggle;
	wire ctrlWr = wrEn && hitCtrl;
	wire cmdStart = wrEn && hitCmd && req.pwdata[START_BIT];
	wire cmdStop = wrEn && hitCmd && req.pwdata[STOP_BIT];

	wire trig_type mode = trig_type'(ctrl_q.trigMode);
	wire map_type mapSel = map_type'(ctrl_q.mapSel);

	wire selEvent = eventPulse[ctrl_q.srcSel];

	wire perStart = (mode == TRIG_PERIODIC) && periodOverflow;
	wire oneStart = (mode == TRIG_SINGLE) && (pending_q || cmdStart) && !busy_q;
	wire evtStart = (mode == TRIG_EVENT) && selEvent;
	wire startNow = (perStart || evtStart || oneStart) && !busy_q;

	// Mapping choice for the active channel
	wire swapDirect = 1'b0;
	wire swapHalves = 1'b1;
	wire swapToggle = toggle_q[activeChan];
	wire swapDecoder = decoderSwap[activeChan];
	logic swapSel;

	always_comb
	begin
		unique case (mapSel)
			MAP_DIRECT: swapSel = swapDirect;
			MAP_SWAPPED: swapSel = swapHalves;
			MAP_TOGGLE: swapSel = swapToggle;
			MAP_DECODER: swapSel = swapDecoder;
		endcase
	end

	wire [31:0] ctrlWord = {23'h000000, ctrl_q.mapSel, 2'h0, ctrl_q.srcSel, ctrl_q.trigMode};
	wire [31:0] ctrlMasked = req.pwdata & CTRL_WMASK;
	wire [31:0] statusWord = {30'h00000000, pending_q, busy_q};
	wire [31:0] toggleWord = {16'h0000, toggle_q};
	wire [31:0] rdMux = hitCtrl ? ctrlWord :
		hitStatus ? statusWord :
		hitToggle ? toggleWord : ZERO_WORD;

	// Control register
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			ctrl_q <= '{mapSel: CTRL_RESET[MAP_MSB:MAP_LSB], srcSel: CTRL_RESET[SRC_MSB:SRC_LSB],
				trigMode: CTRL_RESET[MODE_MSB:MODE_LSB]};
		else if (ctrlWr)
			ctrl_q <= '{mapSel: ctrlMasked[MAP_MSB:MAP_LSB], srcSel: ctrlMasked[SRC_MSB:SRC_LSB],
				trigMode: ctrlMasked[MODE_MSB:MODE_LSB]};
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			pending_q <= 1'b0;
		else if (cmdStart)
			pending_q <= !oneStart || pending_q;
		else if (oneStart)
			pending_q <= 1'b0;
		else if (cmdStop || mode != TRIG_SINGLE)
			pending_q <= 1'b0;
	end

	// Busy spans start to done or stop; periodic and event starts while busy are dropped, single starts stay pending
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			busy_q <= 1'b0;
		else if (startNow)
			busy_q <= 1'b1;
		else if (scanDone || cmdStop)
			busy_q <= 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			start_q <= 1'b0;
		else
			start_q <= startNow;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			toggle_q <= '0;
		else if (mapSel != MAP_TOGGLE)
			toggle_q <= '0;
		else
			toggle_q <= toggle_q ^ chanTrigger;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			cfg_q <= '0;
		else
			cfg_q <= cfg_index(activeChan, swapSel);
	end

	// Read data held after each read access; during the access prdata comes straight from rdMux
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			rdHold_q <= ZERO_WORD;
		else if (access && !req.pwrite)
			rdHold_q <= rdMux;
	end

	// One driver for the whole response struct
	assign rsp = '{pready: 1'b1, pslverr: access && !mapped, prdata: rdHold_q};

	assign pready = rsp.pready;
	assign pslverr = rsp.pslverr;
	assign prdata = (access && !req.pwrite) ? rdMux : rsp.prdata;
	assign scanStart = start_q;
	assign scanBusy = busy_q;
	assign configIndex = cfg_q;

endmodule : scan_config_select

// ===== verif/scan_config_select_asserts.sv
/*
 Port-level checks for scan_config_select.
 Assumes all inputs are on sys_clk except eventIn.
*/
`timescale 1ns/1ps
module scan_config_select_asserts
(
	// Clock, reset, APB
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Sequencer side
	input wire logic periodOverflow,
	input wire logic [7:0] eventIn,
	input wire logic [15:0] decoderSwap,
	input wire logic [3:0] activeChan,
	input wire logic scanStart,
	input wire logic scanBusy,
	input wire logic [3:0] configIndex
);
	import scan_select_pkg::*;
	logic [31:0] ctrl_q;
	wire acc = psel && penable;
	// Shadow of control, APB has no wait states
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			ctrl_q <= ZERO_WORD;
		else if (acc && pwrite && paddr == CTRL_ADDR)
			ctrl_q <= pwdata & CTRL_WMASK;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	chk_ctrl_readback: assert property (acc && !pwrite && paddr == CTRL_ADDR |-> prdata == ctrl_q)
		else $error("ctrl readback");
	chk_map_direct: assert property ($past(resetn) && $past(ctrl_q[8:7]) == 0
		|-> configIndex == $past(activeChan)) else $error("direct map");
	chk_map_swap: assert property ($past(resetn) && $past(ctrl_q[8:7]) == 1
		|-> configIndex == ($past(activeChan) ^ 4'h8)) else $error("swap map");
	chk_map_decoder: assert property ($past(resetn) && $past(ctrl_q[8:7]) == 3
		|-> configIndex == ($past(activeChan) ^ {$past(decoderSwap[activeChan]), 3'h0})) else $error("decoder map");
	chk_periodic_start: assert property (ctrl_q[1:0] == 0 && periodOverflow && !scanBusy |=> scanStart)
		else $error("periodic start");
	chk_start_busy: assert property (scanStart |-> scanBusy)
		else $error("start without busy");
	chk_single_start: assert property (acc && pwrite && paddr == CMD_ADDR && pwdata[0] && ctrl_q[1:0] == 1
		&& !scanBusy |-> ##[1:2] scanStart) else $error("single start");
	chk_event_start: assert property (ctrl_q[1:0] == 2 && $rose(eventIn[ctrl_q[4:2]]) && !scanBusy
		|-> ##[1:5] scanStart) else $error("event start");
endmodule : scan_config_select_asserts
bind scan_config_select scan_config_select_asserts scan_config_select_asserts_inst (.sys_clk, .resetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .periodOverflow, .eventIn, .decoderSwap, .activeChan, .scanStart,
	.scanBusy, .configIndex);

// ===== verif/tb_top.sv
/*
 Self-checking bench for scan_config_select.
 Assumes zero-wait APB and the bound checker.
*/
`timescale 1ns/1ps
module tb_top;
	import scan_select_pkg::*;
	logic sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, periodOverflow = 0, scanDone = 0, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, r, n;
	logic [7:0] eventIn = 0;
	logic [15:0] chanTrigger = 0, decoderSwap = 16'h0020;
	logic [3:0] activeChan = 4'h5;
	wire pready, pslverr, scanStart, scanBusy;
	wire [31:0] prdata;
	wire [3:0] configIndex;
	int errorCnt = 0, compares = 0, cyc = 0;
	scan_config_select scan_config_select_inst (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .pslverr, .prdata, .periodOverflow, .eventIn, .scanDone, .chanTrigger, .decoderSwap,
		.activeChan, .scanStart, .scanBusy, .configIndex);
	always #4 sys_clk = ~sys_clk;
	// Hang guard, tests need under 400 cycles
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			errorCnt++;
			wrapUp;
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1);
		r = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task chk(string s, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e)
			$display("Error %s expected %h seen %h", s, e, g);
		if (g !== e)
			errorCnt++;
	endtask : chk
	task count(int k);
		repeat (k) @(negedge sys_clk) n += scanStart;
	endtask : count
	task end_scan;
		@(posedge sys_clk) scanDone <= 1;
		@(posedge sys_clk) scanDone <= 0;
	endtask : end_scan
	task t_map;
		apb(0, CTRL_ADDR, 0);
		chk("ctrl reset", CTRL_RESET, r);
		apb(0, 12'h040, 0);
		chk("unmapped err", 1, err);
		for (int m = 0; m < 4; m++)
		begin
			apb(1, CTRL_ADDR, 32'h3 | m << 7);
			repeat (3) @(posedge sys_clk);
			#1 chk("config index", m[0] ? 13 : 5, configIndex);
		end
		$display("map test done");
	endtask : t_map
	task t_toggle;
		apb(1, CTRL_ADDR, 32'h103);
		activeChan <= 3;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge sys_clk) chanTrigger <= 16'h0008;
			@(posedge sys_clk) chanTrigger <= 0;
			repeat (2) @(posedge sys_clk);
			#1 chk("toggle", i[0] ? 3 : 11, configIndex);
		end
		$display("toggle test done");
	endtask : t_toggle
	task t_starts;
		apb(1, CTRL_ADDR, 0);
		@(posedge sys_clk) periodOverflow <= 1;
		@(posedge sys_clk) periodOverflow <= 0;
		#1 chk("periodic start", 1, scanStart);
		end_scan;
		apb(1, CTRL_ADDR, 1);
		n = 0;
		apb(1, CMD_ADDR, 1);
		count(6);
		end_scan;
		@(posedge sys_clk) periodOverflow <= 1;
		@(posedge sys_clk) periodOverflow <= 0;
		count(4);
		chk("single scans", 1, n);
		$display("start test done");
	endtask : t_starts
	task t_event;
		apb(1, CTRL_ADDR, 32'h16);
		n = 0;
		@(posedge sys_clk) eventIn <= 8'h10;
		count(6);
		chk("other channel", 0, n);
		@(posedge sys_clk) eventIn <= 8'h30;
		count(6);
		chk("event scans", 1, n);
		end_scan;
		$display("event test done");
	endtask : t_event
	task t_status;
		apb(1, CTRL_ADDR, 0);
		@(posedge sys_clk) periodOverflow <= 1;
		@(posedge sys_clk) periodOverflow <= 0;
		#1 chk("busy pin", 1, scanBusy);
		apb(0, STATUS_ADDR, 0);
		chk("status busy", 1, r);
		chk("mapped no err", 0, err);
		chk("ready", 1, pready);
		n = 0;
		@(posedge sys_clk) periodOverflow <= 1;
		@(posedge sys_clk) periodOverflow <= 0;
		count(3);
		chk("drop while busy", 0, n);
		apb(1, CMD_ADDR, 2);
		apb(0, STATUS_ADDR, 0);
		chk("stop clears", 0, r);
		apb(1, CTRL_ADDR, 1);
		apb(1, CMD_ADDR, 1);
		apb(1, CMD_ADDR, 1);
		apb(0, STATUS_ADDR, 0);
		chk("pending", 3, r);
		n = 0;
		end_scan;
		count(4);
		chk("pending scan", 1, n);
		apb(1, CMD_ADDR, 2);
		apb(1, CTRL_ADDR, 3);
		n = 0;
		@(posedge sys_clk) periodOverflow <= 1;
		@(posedge sys_clk) periodOverflow <= 0;
		count(3);
		chk("no trigger", 0, n);
		$display("status test done");
	endtask : t_status
	task wrapUp;
		$display("compares %0d errors %0d", compares, errorCnt);
		if (errorCnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrapUp
	initial
	begin
		repeat (4) @(posedge sys_clk);
		resetn <= 1;
		t_map;
		t_toggle;
		t_starts;
		t_event;
		t_status;
		wrapUp;
	end
endmodule : tb_top
